// ### isa_decode_pkg.sv
// Operation
// RULE1: Input is a stream of halfword-aligned halfwords forming 16- or 32-bit instructions.
// RULE2: Top five bits 11101, 11110 or 11111 start a 32-bit instruction.
// RULE3: Unallocated encodings are classed unpredictable or raise undefined instruction.
// RULE4: Encodings declared undefined raise the undefined instruction exception.
// RULE5: A fixed bit holding the opposite value makes the encoding unpredictable.
// RULE6: A 32-bit instruction of an absent extension is undefined.
// RULE7: The all-ones register specifier is rejected except where an encoding allows it.
// RULE8: An allowed all-ones source specifier reads instruction address plus four.
// RULE9: Table branch byte and halfword accept the program counter as base.
// RULE10: FP load/store multiple, push and pop move one to sixteen registers.
// RULE11: FP single load and store move exactly one register.
// RULE12: Single and double registers are two views of one register file.
// RULE13: Transfer group moves words, word pairs and FP system registers.
// RULE14: Word-aligned program counter base reads address plus four, low bits cleared.
// RULE15: A 32-bit instruction issues only after its second halfword arrives.
package isa_decode_pkg;
	localparam logic [4:0] PREFIX_A = 5'h1D;
	localparam logic [4:0] PREFIX_B = 5'h1E;
	localparam logic [4:0] PREFIX_C = 5'h1F;
	localparam logic [3:0] REG_PC = 4'hF;
	localparam logic [31:0] PC_OFFSET = 32'h0000_0004;
	localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;
	localparam logic [3:0] COPROC_FP_S = 4'hA;
	localparam logic [3:0] COPROC_FP_D = 4'hB;
	localparam logic [4:0] MAX_REGS = 5'h10;
	localparam logic [5:0] MAX_SINGLES = 6'h20;
	localparam logic [11:0] TBR_HI = 12'hE8D;
	localparam logic [3:0] TBR_LO_FIX = 4'hF;
	localparam logic [3:0] TBR_OP_BYTE = 4'h0;
	localparam logic [3:0] TBR_OP_HALF = 4'h1;
	localparam logic [3:0] REG_SP = 4'hD;
	localparam logic [2:0] FPLS_TOP = 3'h6;
	localparam logic [3:0] XFER64_OP = 4'h2;
	localparam logic [2:0] SYSREG_OP = 3'h7;
	localparam logic [3:0] FPXFER_TOP = 4'hE;
	localparam logic [3:0] UNDEF_16_TOP = 4'hD;
	localparam logic [3:0] UNDEF_16_COND = 4'hE;
	typedef enum {
		ST_FIRST,
		ST_SECOND
	} dec_state_t;
	typedef enum logic [3:0] {
		CLS_OTHER = 4'h0,
		CLS_TABLE_BRANCH_BYTE = 4'h1,
		CLS_TABLE_BRANCH_HALFWORD = 4'h2,
		CLS_FP_LOAD_MULTIPLE = 4'h3,
		CLS_FP_STORE_MULTIPLE = 4'h4,
		CLS_FP_STACK_PUSH = 4'h5,
		CLS_FP_STACK_POP = 4'h6,
		CLS_FP_LOAD_SINGLE = 4'h7,
		CLS_FP_STORE_SINGLE = 4'h8,
		CLS_FP_REGISTER_COPY = 4'h9,
		CLS_FP_SYSREG_TO_CORE = 4'hA,
		CLS_CORE_TO_FP_SYSREG = 4'hB,
		CLS_FP_DATA = 4'hC
	} insn_class_t;
endpackage

// ### isa_decode.sv
`timescale 1ns/100ps
`default_nettype none
module isa_decode
	import isa_decode_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Halfword stream from fetch.
	input wire logic hw_valid_in,
	input wire logic [15:0] hw_data_in,
	input wire logic [31:0] hw_addr_in,
	input wire logic flush_in,
	// Implementation options.
	input wire logic fp_present_in,
	// Decoded instruction.
	output logic insn_valid_out,
	output logic insn_is32_out,
	output logic [31:0] insn_out,
	output logic [31:0] insn_addr_out,
	output logic [3:0] insn_class_out,
	output logic undefined_out,
	output logic unpredictable_out,
	output logic [31:0] pc_read_out,
	output logic [31:0] pc_aligned_out,
	output logic [4:0] fp_reg_count_out,
	output logic fp_reg_double_out
);

	function automatic logic is_prefix(input logic [15:0] hw);
		return hw[15:11] == PREFIX_A || hw[15:11] == PREFIX_B ||
			hw[15:11] == PREFIX_C; // see RULE2
	endfunction

	function automatic logic is_fp_cp(input logic [3:0] cp);
		return cp == COPROC_FP_S || cp == COPROC_FP_D;
	endfunction

	// ---------------------------------------------------------------
	// Halfword pairing
	// ---------------------------------------------------------------
	dec_state_t state, next_state;
	logic [15:0] first_hw, next_first_hw;
	logic [31:0] first_addr, next_first_addr;

	always_comb begin
		next_state = state;
		next_first_hw = first_hw;
		next_first_addr = first_addr;
		if (flush_in) begin
			next_state = ST_FIRST;
		end else if (hw_valid_in) begin
			case (state)
				ST_FIRST: begin
					if (is_prefix(hw_data_in)) begin // see RULE1
						next_state = ST_SECOND; // see RULE15
						next_first_hw = hw_data_in;
						next_first_addr = hw_addr_in;
					end
				end
				ST_SECOND: next_state = ST_FIRST;
				default: next_state = ST_FIRST;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_FIRST;
			first_hw <= 16'h0000;
			first_addr <= 32'h0000_0000;
		end else begin
			state <= next_state;
			first_hw <= next_first_hw;
			first_addr <= next_first_addr;
		end
	end

	// ---------------------------------------------------------------
	// Classification of the instruction being issued
	// ---------------------------------------------------------------
	logic issue, is32;
	logic [31:0] word, addr;
	insn_class_t cls;
	logic undef, unpred, dbl;
	logic [4:0] cnt;
	logic [7:0] imm8;
	logic [3:0] rn;

	always_comb begin
		issue = 1'b0;
		is32 = 1'b0;
		word = {16'h0000, hw_data_in};
		addr = hw_addr_in;
		if (hw_valid_in && !flush_in) begin
			if (state == ST_SECOND) begin
				issue = 1'b1; // see RULE15
				is32 = 1'b1;
				word = {first_hw, hw_data_in}; // see RULE1
				addr = first_addr;
			end else begin
				issue = !is_prefix(hw_data_in);
			end
		end
	end

	always_comb begin
		cls = CLS_OTHER;
		undef = 1'b0;
		unpred = 1'b0;
		dbl = word[8];
		imm8 = word[7:0];
		rn = word[19:16];
		cnt = 5'h00;
		if (!is32) begin
			// Permanently undefined 16-bit space in the branch group.
			if (word[15:12] == UNDEF_16_TOP && word[11:8] == UNDEF_16_COND)
				undef = 1'b1; // see RULE4
		end else if (word[31:20] == TBR_HI && (word[7:4] == TBR_OP_BYTE
				|| word[7:4] == TBR_OP_HALF)) begin
			cls = word[4] ? CLS_TABLE_BRANCH_HALFWORD :
				CLS_TABLE_BRANCH_BYTE;
			// Base may be the program counter; index may not.
			if (word[15:12] != TBR_LO_FIX || word[11:8] != 4'h0)
				unpred = 1'b1; // see RULE5
			if (word[3:0] == REG_PC)
				unpred = 1'b1; // see RULE7
			// Base of all ones is accepted here.  see RULE9
			// Index bits 24:23 of 00 belong to the pair transfers, and 11
			// with writeback is unallocated, so both fall through here.
		end else if (word[27:25] == FPLS_TOP && is_fp_cp(word[11:8])
				&& (word[24] ? !(word[23] && word[21]) : word[23])) begin
			dbl = word[8]; // see RULE12
			// Pre-indexed without writeback moves a single register.
			if (word[24] && !word[21]) begin
				cls = word[20] ? CLS_FP_LOAD_SINGLE : CLS_FP_STORE_SINGLE;
				cnt = 5'h01; // see RULE11
			end else begin
				if (rn == REG_SP && word[21])
					cls = word[20] ? CLS_FP_STACK_POP : CLS_FP_STACK_PUSH;
				else
					cls = word[20] ? CLS_FP_LOAD_MULTIPLE :
						CLS_FP_STORE_MULTIPLE;
				cnt = dbl ? imm8[5:1] : imm8[4:0];
				// Zero or more than sixteen registers is not a legal list.
				if (imm8 == 8'h00 || (dbl && imm8[7:1] > {2'b00, MAX_REGS})
						|| (!dbl && imm8 > {3'b000, MAX_REGS}))
					unpred = 1'b1; // see RULE10
				if (dbl && imm8[0])
					unpred = 1'b1; // see RULE5
				if (!dbl && ({1'b0, word[15:12], word[22]} +
						{1'b0, imm8[4:0]}) > MAX_SINGLES)
					unpred = 1'b1; // see RULE10
				if (rn == REG_PC && word[21])
					unpred = 1'b1; // see RULE7
			end
		end else if (word[27:24] == FPXFER_TOP && is_fp_cp(word[11:8])) begin
			if (word[4]) begin
				if (word[23:21] == SYSREG_OP && word[11:8] == COPROC_FP_S) begin
					cls = word[20] ? CLS_FP_SYSREG_TO_CORE :
						CLS_CORE_TO_FP_SYSREG; // see RULE13
					if (!word[20] && word[15:12] == REG_PC)
						unpred = 1'b1; // see RULE7
				end else begin
					cls = CLS_FP_REGISTER_COPY; // see RULE13
					if (word[15:12] == REG_PC)
						unpred = 1'b1; // see RULE7
				end
			end else begin
				cls = CLS_FP_DATA;
			end
		end else if (word[27:25] == FPLS_TOP && word[24:21] == XFER64_OP
				&& is_fp_cp(word[11:8])) begin
			cls = CLS_FP_REGISTER_COPY; // see RULE13
			cnt = 5'h02;
			if (word[15:12] == REG_PC || word[19:16] == REG_PC)
				unpred = 1'b1; // see RULE7
		end
		// FP classes without the extension are undefined.
		if (is32 && cls != CLS_OTHER && cls != CLS_TABLE_BRANCH_BYTE
				&& cls != CLS_TABLE_BRANCH_HALFWORD && !fp_present_in)
			undef = 1'b1; // see RULE6
		// Unallocated coprocessor space on FP numbers stays undefined.
		if (is32 && cls == CLS_OTHER && word[27:26] == 2'b11
				&& is_fp_cp(word[11:8]))
			undef = 1'b1; // see RULE3
		if (undef)
			unpred = 1'b0; // see RULE3
	end

	// ---------------------------------------------------------------
	// Output registers
	// ---------------------------------------------------------------
	logic next_valid;
	logic [31:0] next_pc, next_pca;

	always_comb begin
		next_valid = issue;
		next_pc = addr + PC_OFFSET; // see RULE8
		next_pca = next_pc & WORD_ALIGN_MASK; // see RULE14
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			insn_valid_out <= 1'b0;
			insn_is32_out <= 1'b0;
			insn_out <= 32'h0000_0000;
			insn_addr_out <= 32'h0000_0000;
			insn_class_out <= 4'h0;
			undefined_out <= 1'b0;
			unpredictable_out <= 1'b0;
			pc_read_out <= 32'h0000_0000;
			pc_aligned_out <= 32'h0000_0000;
			fp_reg_count_out <= 5'h00;
			fp_reg_double_out <= 1'b0;
		end else begin
			insn_valid_out <= next_valid;
			insn_is32_out <= is32;
			insn_out <= word;
			insn_addr_out <= addr;
			insn_class_out <= cls;
			undefined_out <= next_valid && undef;
			unpredictable_out <= next_valid && unpred;
			pc_read_out <= next_pc;
			pc_aligned_out <= next_pca;
			fp_reg_count_out <= cnt;
			fp_reg_double_out <= dbl;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_prefix_taken;
		hw_valid_in && !flush_in && state == ST_FIRST && is_prefix(hw_data_in);
	endsequence

	property p_prefix_no_issue;
		@(posedge clk_in) disable iff (rst_in)
		s_prefix_taken |=> !insn_valid_out;
	endproperty
	a_prefix_no_issue: assert property (p_prefix_no_issue) // see RULE2
		else $error("First halfword issued alone.");

	property p_pair_issue;
		@(posedge clk_in) disable iff (rst_in)
		s_prefix_taken ##1 (hw_valid_in && !flush_in) |=>
			insn_valid_out && insn_is32_out;
	endproperty
	a_pair_issue: assert property (p_pair_issue) // see RULE15
		else $error("Pair not issued as 32-bit.");

	property p_short_issue;
		@(posedge clk_in) disable iff (rst_in)
		hw_valid_in && !flush_in && state == ST_FIRST && !is_prefix(hw_data_in)
			|=> insn_valid_out && !insn_is32_out;
	endproperty
	a_short_issue: assert property (p_short_issue) // see RULE1
		else $error("16-bit instruction not issued.");

	property p_pc_plus4;
		@(posedge clk_in) disable iff (rst_in)
		insn_valid_out |-> pc_read_out == insn_addr_out + PC_OFFSET;
	endproperty
	a_pc_plus4: assert property (p_pc_plus4) // see RULE8
		else $error("Program counter read wrong.");

	property p_pc_aligned;
		@(posedge clk_in) disable iff (rst_in)
		insn_valid_out |-> pc_aligned_out[1:0] == 2'b00 &&
			pc_aligned_out[31:2] == pc_read_out[31:2];
	endproperty
	a_pc_aligned: assert property (p_pc_aligned) // see RULE14
		else $error("Aligned program counter wrong.");

	property p_single_one;
		@(posedge clk_in) disable iff (rst_in)
		insn_valid_out && (insn_class_out == CLS_FP_LOAD_SINGLE ||
			insn_class_out == CLS_FP_STORE_SINGLE) |-> fp_reg_count_out == 5'h01;
	endproperty
	a_single_one: assert property (p_single_one) // see RULE11
		else $error("Single transfer count not one.");

	property p_multi_range;
		@(posedge clk_in) disable iff (rst_in)
		insn_valid_out && !unpredictable_out && !undefined_out &&
			(insn_class_out == CLS_FP_LOAD_MULTIPLE ||
			insn_class_out == CLS_FP_STORE_MULTIPLE ||
			insn_class_out == CLS_FP_STACK_POP ||
			insn_class_out == CLS_FP_STACK_PUSH) |->
			fp_reg_count_out != 5'h00 && fp_reg_count_out <= MAX_REGS;
	endproperty
	a_multi_range: assert property (p_multi_range) // see RULE10
		else $error("Multiple transfer count out of range.");

	property p_no_fp_undef;
		@(posedge clk_in) disable iff (rst_in)
		issue && is32 && !fp_present_in && cls == CLS_FP_DATA |=> undefined_out;
	endproperty
	a_no_fp_undef: assert property (p_no_fp_undef) // see RULE6
		else $error("Absent extension not undefined.");

	property p_exclusive;
		@(posedge clk_in) disable iff (rst_in)
		undefined_out |-> !unpredictable_out && insn_valid_out;
	endproperty
	a_exclusive: assert property (p_exclusive) // see RULE3
		else $error("Undefined and unpredictable together.");

endmodule // isa_decode
`default_nettype wire

// ### fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
	// Clock.
	input wire logic clk_in,
	// Halfword stream.
	output logic hw_valid_out,
	output logic [15:0] hw_data_out,
	output logic [31:0] hw_addr_out
);
	initial begin
		hw_valid_out = 1'b0;
		hw_data_out = 16'h0000;
		hw_addr_out = 32'h0000_0000;
	end
	task automatic put(input logic [15:0] d, input logic [31:0] a);
		hw_valid_out = 1'b1;
		hw_data_out = d;
		hw_addr_out = {a[31:1], 1'b0};
		@(posedge clk_in);
		#1;
	endtask
	// Stale data is inverted each idle cycle, so after an even number of cycles it holds the last value put again.
	task automatic idle(input int n);
		repeat (n) begin
			hw_valid_out = 1'b0;
			hw_data_out = ~hw_data_out;
			hw_addr_out = ~hw_addr_out;
			@(posedge clk_in);
			#1;
		end
	endtask
endmodule // fetch_model
`default_nettype wire

// ### compact_isa_length_and_fp_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) check_val(32'(a), 32'(b));
module compact_isa_length_and_fp_decode_test;
	import isa_decode_pkg::*;
	typedef struct {
		logic [15:0] hi, lo;
		logic fp;
		logic [3:0] cls;
		logic [4:0] cnt;
		logic dbl, und, unp;
	} row_t;
	logic clk_in, rst_in, flush_in, fp_present_in;
	logic hw_valid, insn_valid_out, insn_is32_out, undefined_out;
	logic unpredictable_out, fp_reg_double_out;
	logic [15:0] hw_data;
	logic [31:0] hw_addr, insn_out, insn_addr_out, pc_read_out;
	logic [31:0] pc_aligned_out, addr;
	logic [3:0] insn_class_out;
	logic [4:0] fp_reg_count_out;
	int fails, compares;
	row_t rows[15];
	fetch_model i_fetch_model (.clk_in(clk_in), .hw_valid_out(hw_valid),
		.hw_data_out(hw_data), .hw_addr_out(hw_addr));
	isa_decode i_isa_decode (.clk_in(clk_in), .rst_in(rst_in),
		.hw_valid_in(hw_valid), .hw_data_in(hw_data),
		.hw_addr_in(hw_addr), .flush_in(flush_in),
		.fp_present_in(fp_present_in), .insn_valid_out(insn_valid_out),
		.insn_is32_out(insn_is32_out), .insn_out(insn_out),
		.insn_addr_out(insn_addr_out), .insn_class_out(insn_class_out),
		.undefined_out(undefined_out),
		.unpredictable_out(unpredictable_out),
		.pc_read_out(pc_read_out), .pc_aligned_out(pc_aligned_out),
		.fp_reg_count_out(fp_reg_count_out),
		.fp_reg_double_out(fp_reg_double_out));
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic run(input logic [15:0] h, input logic [15:0] l,
		input logic is32, input int gap);
		logic [31:0] a;
		a = addr;
		i_fetch_model.put(h, a);
		if (is32) begin
			i_fetch_model.idle(gap);
			`CHK(insn_valid_out, 1'b0)
			i_fetch_model.put(l, a + 32'h2);
		end
		`CHK(insn_valid_out, 1'b1)
		`CHK(insn_is32_out, is32)
		`CHK(insn_out, is32 ? {h, l} : {16'h0000, h})
		`CHK(insn_addr_out, a)
		`CHK(pc_read_out, a + PC_OFFSET)
		`CHK(pc_aligned_out, (a + 32'h4) & WORD_ALIGN_MASK)
		addr = a + (is32 ? 32'h4 : 32'h2);
	endtask
	task automatic t_length();
		run(16'h4600, 16'h0000, 1'b0, 0);
		run(16'hE000, 16'h0000, 1'b0, 0);
		for (int p = 29; p < 32; p++) begin
			run({5'(p), 11'h000}, 16'h0000, 1'b1, p - 29);
		end
	endtask
	task automatic t_table_branch();
		run(16'hE8DF, 16'hF000, 1'b1, 3);
		`CHK(insn_class_out, CLS_TABLE_BRANCH_BYTE)
		`CHK(undefined_out, 1'b0)
		run(16'hE8DF, 16'hF010, 1'b1, 0);
		`CHK(insn_class_out, CLS_TABLE_BRANCH_HALFWORD)
		`CHK(unpredictable_out, 1'b0)
		run(16'hE8DF, 16'hF100, 1'b1, 0);
		`CHK(unpredictable_out, 1'b1)
		run(16'hE8DF, 16'hF00F, 1'b1, 0);
		`CHK(unpredictable_out, 1'b1)
	endtask
	task automatic t_undefined();
		run(16'hDE00, 16'h0000, 1'b0, 0);
		`CHK(undefined_out, 1'b1)
		`CHK(unpredictable_out, 1'b0)
	endtask
	task automatic t_fp();
		rows = '{'{16'hED90, 16'h0A01, 1, CLS_FP_LOAD_SINGLE, 1, 0, 0, 0},
			'{16'hED80, 16'h0B01, 1, CLS_FP_STORE_SINGLE, 1, 1, 0, 0},
			'{16'hEC90, 16'h0A10, 1, CLS_FP_LOAD_MULTIPLE, 16, 0, 0, 0},
			'{16'hEC90, 16'h0B08, 1, CLS_FP_LOAD_MULTIPLE, 4, 1, 0, 0},
			'{16'hEC80, 16'h0A01, 1, CLS_FP_STORE_MULTIPLE, 1, 0, 0, 0},
			'{16'hECBD, 16'h0A02, 1, CLS_FP_STACK_POP, 2, 0, 0, 0},
			'{16'hED2D, 16'h0B04, 1, CLS_FP_STACK_PUSH, 2, 1, 0, 0},
			'{16'hEC90, 16'h0A11, 1, CLS_FP_LOAD_MULTIPLE, 0, 0, 0, 1},
			'{16'hEC41, 16'h0A10, 1, CLS_FP_REGISTER_COPY, 2, 0, 0, 0},
			'{16'hEEF1, 16'h0A10, 1, CLS_FP_SYSREG_TO_CORE, 0, 0, 0, 0},
			'{16'hEEE1, 16'h0A10, 1, CLS_CORE_TO_FP_SYSREG, 0, 0, 0, 0},
			'{16'hED90, 16'h0A01, 0, CLS_FP_LOAD_SINGLE, 0, 0, 1, 0},
			'{16'hEE30, 16'h0A00, 1, CLS_FP_DATA, 0, 0, 0, 0},
			'{16'hEE30, 16'h0A00, 0, CLS_FP_DATA, 0, 0, 1, 0},
			'{16'hEDA0, 16'h0A01, 1, CLS_OTHER, 0, 0, 1, 0}};
		foreach (rows[i]) begin
			fp_present_in = rows[i].fp;
			run(rows[i].hi, rows[i].lo, 1'b1, 0);
			`CHK(insn_class_out, rows[i].cls)
			`CHK(fp_reg_double_out, rows[i].dbl)
			`CHK(undefined_out, rows[i].und)
			`CHK(unpredictable_out, rows[i].unp)
			if (rows[i].cnt != 5'h00)
				`CHK(fp_reg_count_out, rows[i].cnt)
		end
		fp_present_in = 1'b1;
	endtask
	task automatic t_flush();
		i_fetch_model.put(16'hE8DF, addr);
		flush_in = 1'b1;
		i_fetch_model.put(16'h4600, addr + 32'h2);
		flush_in = 1'b0;
		`CHK(insn_valid_out, 1'b0)
		addr = addr + 32'h2;
		run(16'h4600, 16'h0000, 1'b0, 0);
	endtask
	initial begin
		#20000;
		fails++;
		results();
	end
	initial begin
		fails = 0;
		compares = 0;
		addr = 32'h0000_0102;
		rst_in = 1'b1;
		flush_in = 1'b0;
		fp_present_in = 1'b1;
		repeat (10) @(posedge clk_in);
		#1;
		`CHK(insn_valid_out, 1'b0)
		rst_in = 1'b0;
		t_length();
		t_table_branch();
		t_undefined();
		t_fp();
		t_flush();
		results();
	end
endmodule // compact_isa_length_and_fp_decode_test
`default_nettype wire
